// File: shared/cmd_decode_pkg.sv
// Constants and types shared by the command decoder and its testbench.
package cmd_decode_pkg;

	// Address and bank widths of the largest supported configuration.
	localparam int ADDR_W = 15;
	localparam int BANK_W = 3;
	localparam int AP_BIT = 10;

	// Density codes; the third bank bit is used only from the 1 Gb code up.
	localparam logic [1:0] DENS_512M = 2'h0;
	localparam logic [1:0] DENS_1G   = 2'h1;
	localparam logic [1:0] DENS_2G   = 2'h2;

	// Row address width per density, and the column width in use.
	localparam int ROW_W_512M = 14;
	localparam int ROW_W_1G   = 14;
	localparam int ROW_W_2G   = 15;
	localparam int COL_W      = 10;

	// Decoded command codes.
	typedef enum logic [3:0] {
		CMD_NONE     = 4'h0,
		CMD_DESELECT = 4'h1,
		CMD_NOP      = 4'h2,
		CMD_MODE     = 4'h3,
		CMD_REFRESH  = 4'h4,
		CMD_SR_ENTER = 4'h5,
		CMD_SR_EXIT  = 4'h6,
		CMD_PRE      = 4'h7,
		CMD_PRE_ALL  = 4'h8,
		CMD_ACTIVATE = 4'h9,
		CMD_WRITE    = 4'hA,
		CMD_READ     = 4'hB,
		CMD_PD_ENTER = 4'hC,
		CMD_PD_EXIT  = 4'hD,
		CMD_ILLEGAL  = 4'hE
	} cmd_e;

	// Power state of the device.
	typedef enum logic [1:0] {
		PS_ACTIVE    = 2'b00,
		PS_POWERDOWN = 2'b01,
		PS_SELFREF   = 2'b10
	} pstate_e;

endpackage : cmd_decode_pkg

// File: sim/ctrl_model.sv
// Controller model: drives the link clock and the command and address pins.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
	output logic        link_clk,
	output logic        clk_en,
	output logic        sel_n,
	output logic        row_strobe_n,
	output logic        col_strobe_n,
	output logic        wr_en_n,
	output logic        term_ctl,
	output logic [2:0]  bank_addr,
	output logic [14:0] addr
);
	// Clock low and every pin at a defined level from time zero.
	// no floating pins
	initial begin
		link_clk = 1'b0;
		{clk_en, sel_n, row_strobe_n, col_strobe_n, wr_en_n} = 5'h0F;
		term_ctl = 1'b0;
		bank_addr = 3'h0;
		addr = 15'h0000;
	end

	// One link period per command; the clock stands low between commands.
	// pins set before rise
	task automatic send(input logic cke, input logic [3:0] pins,
			input logic [2:0] ba, input logic [14:0] a);
		#31.25;
		clk_en = cke;
		{sel_n, row_strobe_n, col_strobe_n, wr_en_n} = pins;
		bank_addr = ba;
		addr = a;
		#31.25;
		link_clk = 1'b1;
		#62.5;
		link_clk = 1'b0;
	endtask

	// Clock enable may move while the link clock stands still.
	task automatic set_cke(input logic v);
		clk_en = v;
	endtask

	// Termination request level.
	task automatic set_term(input logic v);
		term_ctl = v;
	endtask
endmodule // ctrl_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the command decoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk_sys, nrst, link_clk, clk_en, sel_n, row_strobe_n;
	logic        col_strobe_n, wr_en_n, term_ctl, cmd_valid, cmd_auto_pre;
	logic        mode_load, term_on;
	logic [1:0]  density, power_state;
	logic [2:0]  bank_addr, cmd_bank, mode_sel;
	logic [3:0]  cmd_code, last_code;
	logic [14:0] addr, cmd_row, cmd_col, mode_opcode;
	int          n_errors = 0;
	int          n_checks = 0;
	int          n_valid = 0;
	int          n_load = 0;

	ctrl_model u_ctrl (.link_clk, .clk_en, .sel_n, .row_strobe_n,
		.col_strobe_n, .wr_en_n, .term_ctl, .bank_addr, .addr);

	ddr2_command_decoder u_dut (.clk_sys, .nrst, .link_clk, .clk_en, .sel_n,
		.row_strobe_n, .col_strobe_n, .wr_en_n, .term_ctl, .bank_addr,
		.addr, .density, .cmd_code, .cmd_valid, .cmd_bank, .cmd_row,
		.cmd_col, .cmd_auto_pre, .mode_sel, .mode_opcode, .mode_load,
		.power_state, .term_on);

	// System clock at 100 MHz.
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	// Pulses last one cycle, so they are counted here rather than polled.
	always @(posedge clk_sys) begin
		if (cmd_valid === 1'b1) begin
			n_valid <= n_valid + 1;
			last_code <= cmd_code;
		end
		if (mode_load === 1'b1)
			n_load <= n_load + 1;
	end

	// Compares one value and counts the outcome.
	task automatic chk(input string name, input logic [14:0] seen,
			input logic [14:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Sends one command and expects exactly one decode with the given code.
	task automatic do_cmd(input logic cke, input logic [3:0] p,
			input logic [2:0] ba, input logic [14:0] a, input logic [3:0] e);
		int nv;
		nv = n_valid;
		u_ctrl.send(cke, p, ba, a);
		repeat (2) @(posedge clk_sys);
		chk("pulses", 15'(n_valid - nv), 15'h0001);
		chk("code", 15'(last_code), 15'(e));
	endtask

	// Strobe decodes, mode load fields and the first edge after reset.
	task automatic t_decode();
		do_cmd(1'b1, 4'hF, 3'h0, 15'h0000, cmd_decode_pkg::CMD_PD_EXIT);
		do_cmd(1'b1, 4'h0, 3'h5, 15'h2ABC, cmd_decode_pkg::CMD_MODE);
		chk("mode_sel", 15'(mode_sel), 15'h0005);
		chk("opcode", mode_opcode, 15'h2ABC);
		chk("loads", 15'(n_load), 15'h0001);
		do_cmd(1'b1, 4'h1, 3'h0, 15'h0000, cmd_decode_pkg::CMD_REFRESH);
		do_cmd(1'b1, 4'h3, 3'h6, 15'h7FFF, cmd_decode_pkg::CMD_ACTIVATE);
		chk("row", cmd_row, 15'h7FFF);
		chk("bank", 15'(cmd_bank), 15'h0006);
		do_cmd(1'b1, 4'h2, 3'h2, 15'h0000, cmd_decode_pkg::CMD_PRE);
		do_cmd(1'b1, 4'h2, 3'h2, 15'h0400, cmd_decode_pkg::CMD_PRE_ALL);
		do_cmd(1'b1, 4'h7, 3'h1, 15'h1234, cmd_decode_pkg::CMD_NOP);
		do_cmd(1'b1, 4'h8, 3'h7, 15'h7FFF, cmd_decode_pkg::CMD_DESELECT);
		// An unused strobe pattern must come out as the illegal code.
		do_cmd(1'b1, 4'h6, 3'h0, 15'h0000, cmd_decode_pkg::CMD_ILLEGAL);
		$display("t_decode done");
	endtask

	// Reads and writes with both A10 levels, termination, two densities.
	task automatic t_rdwr();
		logic [14:0] a;
		logic [3:0]  e;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			#1 density = i[1] ? cmd_decode_pkg::DENS_512M
				: cmd_decode_pkg::DENS_1G;
			u_ctrl.set_term(i[0]);
			a = i[0] ? 15'h7FFF : 15'h7BFF;
			e = i[1] ? cmd_decode_pkg::CMD_READ : cmd_decode_pkg::CMD_WRITE;
			do_cmd(1'b1, {3'h2, i[1]}, 3'h7, a, e);
			chk("col", cmd_col, a & 15'h03FF);
			chk("autopre", 15'(cmd_auto_pre), 15'(i[0]));
			chk("rwbank", 15'(cmd_bank), i[1] ? 15'h0003 : 15'h0007);
			chk("term", 15'(term_on), 15'(i[0]));
			do_cmd(1'b1, 4'h7, 3'h0, 15'h0000, cmd_decode_pkg::CMD_NOP);
		end
		do_cmd(1'b1, 4'h3, 3'h7, 15'h7FFF, cmd_decode_pkg::CMD_ACTIVATE);
		chk("row512", cmd_row, 15'h3FFF);
		chk("bank512", 15'(cmd_bank), 15'h0003);
		$display("t_rdwr done");
	endtask

	// Power-down and self refresh entry and exit; termination gating.
	task automatic t_power();
		int nv;
		#1 u_ctrl.set_term(1'b0);
		do_cmd(1'b0, 4'h7, 3'h0, 15'h0000, cmd_decode_pkg::CMD_PD_ENTER);
		chk("pd", 15'(power_state), 15'h0001);
		// Enable low at both edges is no command; power-down must hold.
		nv = n_valid;
		u_ctrl.send(1'b0, 4'h7, 3'h0, 15'h0000);
		repeat (2) @(posedge clk_sys);
		chk("nocmd", 15'(n_valid - nv), 15'h0000);
		chk("pdhold", 15'(power_state), 15'h0001);
		do_cmd(1'b1, 4'h8, 3'h0, 15'h0000, cmd_decode_pkg::CMD_PD_EXIT);
		chk("pdx", 15'(power_state), 15'h0000);
		#1 u_ctrl.set_term(1'b1);
		do_cmd(1'b0, 4'h1, 3'h0, 15'h0000, cmd_decode_pkg::CMD_SR_ENTER);
		chk("sr", 15'(power_state), 15'h0002);
		chk("srterm", 15'(term_on), 15'h0000);
		#1 u_ctrl.set_cke(1'b1);
		repeat (8) @(posedge clk_sys);
		chk("srx", 15'(power_state), 15'h0000);
		chk("srxterm", 15'(term_on), 15'h0001);
		$display("t_power done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Reset for five cycles, then the scenarios in order.
	initial begin
		nrst = 1'b0;
		density = cmd_decode_pkg::DENS_2G;
		repeat (5) @(posedge clk_sys);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk_sys);
		t_decode();
		t_rdwr();
		t_power();
		print_verdict();
	end

	// The whole run needs about 3.3 us; far beyond that means a hang.
	initial begin
		#100000;
		n_errors++;
		print_verdict();
	end
endmodule // tb
`default_nettype wire

// File: src/ddr2_command_decoder.sv
// Command decoder front end of a double-data-rate memory device.
`timescale 1ns/1ps
`default_nettype none
module ddr2_command_decoder (
	input  wire logic                                clk_sys,
	input  wire logic                                nrst,
	input  wire logic                                link_clk,
	input  wire logic                                clk_en,
	input  wire logic                                sel_n,
	input  wire logic                                row_strobe_n,
	input  wire logic                                col_strobe_n,
	input  wire logic                                wr_en_n,
	input  wire logic                                term_ctl,
	input  wire logic [cmd_decode_pkg::BANK_W-1:0]   bank_addr,
	input  wire logic [cmd_decode_pkg::ADDR_W-1:0]   addr,
	input  wire logic [1:0]                          density,
	output logic      [3:0]                          cmd_code,
	output logic                                     cmd_valid,
	output logic      [cmd_decode_pkg::BANK_W-1:0]   cmd_bank,
	output logic      [cmd_decode_pkg::ADDR_W-1:0]   cmd_row,
	output logic      [cmd_decode_pkg::ADDR_W-1:0]   cmd_col,
	output logic                                     cmd_auto_pre,
	output logic      [cmd_decode_pkg::BANK_W-1:0]   mode_sel,
	output logic      [cmd_decode_pkg::ADDR_W-1:0]   mode_opcode,
	output logic                                     mode_load,
	output logic      [1:0]                          power_state,
	output logic                                     term_on
);

	localparam int NPIN = 7 + cmd_decode_pkg::BANK_W + cmd_decode_pkg::ADDR_W;

	logic                rst_meta_q;
	logic                rst_n;
	logic [NPIN-1:0]     pins_sync;
	logic                link_sync;
	logic                link_rise;
	logic                cke_prev_q;
	logic [1:0]          dens_q;
	cmd_decode_pkg::pstate_e pstate_q;
	cmd_decode_pkg::pstate_e pstate_d;

	// Reset is released through two flops so every flop leaves it together.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Command, address and strap pins cross together in one sampler.
	pin_sampler #(
		.W (NPIN)
	) u_sampler (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.pin       ({clk_en, sel_n, row_strobe_n, col_strobe_n, wr_en_n,
		             density, bank_addr, addr}),
		.link_clk  (link_clk),
		.pin_sync  (pins_sync),
		.link_sync (link_sync),
		.link_rise (link_rise)
	);

	// Named slices of the synchronised pin word.
	wire        s_cke  = pins_sync[NPIN-1];
	wire        s_cs_n = pins_sync[NPIN-2];
	wire        s_ras_n = pins_sync[NPIN-3];
	wire        s_cas_n = pins_sync[NPIN-4];
	wire        s_we_n  = pins_sync[NPIN-5];
	wire [1:0]  s_dens  = pins_sync[NPIN-6 -: 2];
	wire [cmd_decode_pkg::BANK_W-1:0] s_ba =
		pins_sync[cmd_decode_pkg::ADDR_W +: cmd_decode_pkg::BANK_W];
	wire [cmd_decode_pkg::ADDR_W-1:0] s_a =
		pins_sync[cmd_decode_pkg::ADDR_W-1:0];
	wire        s_ap   = s_a[cmd_decode_pkg::AP_BIT];
	wire        in_sr  = (pstate_q == cmd_decode_pkg::PS_SELFREF);
	wire        is_idle = s_cs_n | (s_ras_n & s_cas_n & s_we_n);

	// Termination synchroniser, kept apart since it needs no link edge.
	logic term_meta_q;
	logic term_sync_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			term_meta_q <= 1'b0;
			term_sync_q <= 1'b0;
		end else begin
			term_meta_q <= term_ctl;
			term_sync_q <= term_meta_q;
		end
	end

	// Clear address bits above the row field for the strapped density.
	function automatic logic [cmd_decode_pkg::ADDR_W-1:0] row_mask(
		input logic [1:0] dens
	);
		int w;
		w = (dens == cmd_decode_pkg::DENS_2G) ? cmd_decode_pkg::ROW_W_2G :
		    (dens == cmd_decode_pkg::DENS_1G) ? cmd_decode_pkg::ROW_W_1G :
		    cmd_decode_pkg::ROW_W_512M;
		row_mask = '0;
		for (int i = 0; i < cmd_decode_pkg::ADDR_W; i++) begin
			if (i < w) begin
				row_mask[i] = 1'b1;
			end
		end
	endfunction

	// Bank field; the top bank bit only counts from 1 Gb up.
	function automatic logic [cmd_decode_pkg::BANK_W-1:0] bank_of(
		input logic [cmd_decode_pkg::BANK_W-1:0] ba,
		input logic [1:0]                        dens
	);
		bank_of = ba;
		if (dens == cmd_decode_pkg::DENS_512M) begin
			bank_of[cmd_decode_pkg::BANK_W-1] = 1'b0;
		end
	endfunction

	// Command decode from enable history and strobe levels at the edge.
	// table lookup
	logic [3:0] cmd_d;
	always_comb begin
		cmd_d = cmd_decode_pkg::CMD_ILLEGAL;
		if (cke_prev_q && s_cke) begin
			if (s_cs_n) begin
				cmd_d = cmd_decode_pkg::CMD_DESELECT;
			end else begin
				unique case ({s_ras_n, s_cas_n, s_we_n})
				3'b111: cmd_d = cmd_decode_pkg::CMD_NOP;
				3'b000: cmd_d = cmd_decode_pkg::CMD_MODE;
				3'b001: cmd_d = cmd_decode_pkg::CMD_REFRESH;
				3'b011: cmd_d = cmd_decode_pkg::CMD_ACTIVATE;
				3'b010: cmd_d = s_ap ? cmd_decode_pkg::CMD_PRE_ALL
				                     : cmd_decode_pkg::CMD_PRE;
				3'b100: cmd_d = cmd_decode_pkg::CMD_WRITE;
				3'b101: cmd_d = cmd_decode_pkg::CMD_READ;
				default: cmd_d = cmd_decode_pkg::CMD_ILLEGAL;
				endcase
			end
		end else if (cke_prev_q && !s_cke) begin
			if (!s_cs_n && {s_ras_n, s_cas_n, s_we_n} == 3'b001) begin
				cmd_d = cmd_decode_pkg::CMD_SR_ENTER;
			end else if (is_idle) begin
				cmd_d = cmd_decode_pkg::CMD_PD_ENTER;
			end
		end else if (!cke_prev_q && s_cke) begin
			if (is_idle) begin
				cmd_d = in_sr ? cmd_decode_pkg::CMD_SR_EXIT
				              : cmd_decode_pkg::CMD_PD_EXIT;
			end
		end else begin
			cmd_d = cmd_decode_pkg::CMD_NONE;
		end
	end

	// Power state: entries on link edges; self-refresh exit needs none.
	// clockless exit
	// The same synchronised enable copy feeds decode and exit, so the two
	// can never disagree for a cycle.
	wire sr_exit_async = in_sr & s_cke;
	always_comb begin
		pstate_d = pstate_q;
		if (sr_exit_async) begin
			pstate_d = cmd_decode_pkg::PS_ACTIVE;
		end else if (link_rise) begin
			unique case (cmd_d)
			cmd_decode_pkg::CMD_SR_ENTER: pstate_d = cmd_decode_pkg::PS_SELFREF;
			cmd_decode_pkg::CMD_PD_ENTER:
				pstate_d = cmd_decode_pkg::PS_POWERDOWN;
			cmd_decode_pkg::CMD_PD_EXIT: pstate_d = cmd_decode_pkg::PS_ACTIVE;
			default: pstate_d = pstate_q;
			endcase
		end
	end

	// Density is a strap pin; it crosses with the other pins first.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dens_q     <= cmd_decode_pkg::DENS_512M;
			cke_prev_q <= 1'b0;
			pstate_q   <= cmd_decode_pkg::PS_ACTIVE;
		end else begin
			dens_q     <= s_dens;
			pstate_q   <= pstate_d;
			cke_prev_q <= link_rise ? s_cke : cke_prev_q;
		end
	end

	// Outputs are registered; they change one cycle after the edge.
	// termination unused here
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_code     <= cmd_decode_pkg::CMD_NONE;
			cmd_valid    <= 1'b0;
			cmd_bank     <= '0;
			cmd_row      <= '0;
			cmd_col      <= '0;
			cmd_auto_pre <= 1'b0;
			mode_sel     <= '0;
			mode_opcode  <= '0;
			mode_load    <= 1'b0;
		end else begin
			cmd_valid <= link_rise && cmd_d != cmd_decode_pkg::CMD_NONE;
			mode_load <= link_rise && cmd_d == cmd_decode_pkg::CMD_MODE;
			if (link_rise) begin
				cmd_code     <= cmd_d;
				cmd_bank     <= bank_of(s_ba, dens_q);
				cmd_row      <= s_a & row_mask(dens_q);
				cmd_col      <= {{(cmd_decode_pkg::ADDR_W -
				                  cmd_decode_pkg::COL_W){1'b0}},
				                 s_a[cmd_decode_pkg::COL_W-1:0]};
				cmd_auto_pre <= s_ap;
				if (cmd_d == cmd_decode_pkg::CMD_MODE) begin
					mode_sel    <= bank_of(s_ba, dens_q);
					mode_opcode <= s_a;
				end
			end
		end
	end

	// Termination follows its input except in self refresh.
	// gated by power state
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			term_on     <= 1'b0;
			power_state <= 2'h0;
		end else begin
			term_on     <= term_sync_q & (pstate_d != cmd_decode_pkg::PS_SELFREF);
			power_state <= pstate_d;
		end
	end

	// Checks on the decoder's own outputs.
	a_sr_term_off: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		power_state == 2'h2 |-> !term_on)
		else $error("termination active in self refresh");

	a_write_code: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		link_rise && cke_prev_q && s_cke && !s_cs_n &&
		{s_ras_n, s_cas_n, s_we_n} == 3'b100 |=> cmd_valid && cmd_code == 4'hA
		&& cmd_auto_pre == $past(s_ap))
		else $error("write not decoded");

	a_read_code: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		link_rise && cke_prev_q && s_cke && !s_cs_n &&
		{s_ras_n, s_cas_n, s_we_n} == 3'b101 |=> cmd_code == 4'hB)
		else $error("read not decoded");

	a_edge_only: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		cmd_valid |-> $past(link_rise))
		else $error("command outside link edge");

	a_mode_sel: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		mode_load |-> cmd_code == 4'h3 && mode_sel == cmd_bank &&
		mode_opcode == $past(s_a))
		else $error("mode register select wrong");

	a_bank_small: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		cmd_valid && dens_q == 2'h0 |-> !cmd_bank[2])
		else $error("third bank bit used below 1Gb");

	a_sr_enter: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		link_rise && cmd_d == 4'h5 && !sr_exit_async |=> power_state == 2'h2)
		else $error("self refresh not entered");

	a_sr_exit: assert property (
		@(posedge clk_sys) disable iff (!rst_n)
		in_sr && s_cke |=> power_state == 2'h0)
		else $error("self refresh exit not taken");

endmodule : ddr2_command_decoder
`default_nettype wire

// File: src/pin_sampler.sv
// Pin sampler: two-stage synchroniser and rising-edge finder for link pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sampler #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin,
	input  wire logic         link_clk,
	output logic      [W-1:0] pin_sync,
	output logic              link_sync,
	output logic              link_rise
);

	logic [W-1:0] pin_meta_q;
	logic         clk_meta_q;
	logic         clk_prev_q;

	// Only the second stage is read; the first stage may be metastable.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= '0;
			pin_sync   <= '0;
			clk_meta_q <= 1'b0;
			link_sync  <= 1'b0;
			clk_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= pin;
			pin_sync   <= pin_meta_q;
			clk_meta_q <= link_clk;
			link_sync  <= clk_meta_q;
			clk_prev_q <= link_sync;
		end
	end

	// Pins and the link clock share a delay, so levels sampled here are
	// the levels that stood at the link clock's rising edge.
	assign link_rise = link_sync & ~clk_prev_q;

endmodule : pin_sampler
`default_nettype wire
